// >>> design/relay_drive_cfg.svh
// timing constants and reset values for the relay drive control
`ifndef RELAY_DRIVE_CFG_SVH
`define RELAY_DRIVE_CFG_SVH

`define RLY_CLK_PERIOD_NS  100
`define RLY_QUAL_TIME_US   15000
`define RLY_MAX_PULSE_US   150000
`define RLY_EN_FILT_NS     5000
`define RLY_QUAL_CYC       ((`RLY_QUAL_TIME_US * 1000 + `RLY_CLK_PERIOD_NS - 1) / `RLY_CLK_PERIOD_NS)
`define RLY_MAX_CYC        ((`RLY_MAX_PULSE_US * 1000) / `RLY_CLK_PERIOD_NS)
`define RLY_EN_CYC         (`RLY_EN_FILT_NS / `RLY_CLK_PERIOD_NS)
`define RLY_SYNC_RST       6'h00
`define RLY_PIN_IDLE       1'b0
`define RLY_OE_N_OFF       1'b1

`endif

// >>> design/relay_drive_pkg.sv
// types shared by the relay drive control modules
package relay_drive_pkg;

    typedef enum logic [1:0] {
        Q_IDLE  = 2'b00,
        Q_COUNT = 2'b01,
        Q_QUAL  = 2'b11
    } qual_state_t;

    typedef enum logic {
        D_IDLE  = 1'b0,
        D_DRIVE = 1'b1
    } drive_state_t;

    typedef enum logic {
        CH_A = 1'b0,
        CH_B = 1'b1
    } chan_sel_t;

    typedef enum logic {
        MODE_FOLLOW = 1'b0,
        MODE_FIXED  = 1'b1
    } out_mode_t;

endpackage : relay_drive_pkg

// >>> design/chan_if.sv
// link between the drive controller and one channel qualifier
`timescale 1ns/1ps
interface chan_if;
    logic level;
    logic clr;
    logic counting;
    logic qualified;

    modport ctrl (output level, output clr, input counting, input qualified);
    modport chan (input level, input clr, output counting, output qualified);
endinterface : chan_if

// >>> design/chan_qual.sv
// one command channel: rising edge detect and pulse qualification
`timescale 1ns/1ps
module chan_qual #(
    parameter int QUAL_CYC = 150000,
    parameter int CW       = 18
) (
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    chan_if.chan      ch
);
    relay_drive_pkg::qual_state_t state;
    relay_drive_pkg::qual_state_t next_state;
    logic [CW-1:0]                cnt;
    logic [CW-1:0]                next_cnt;
    logic                         prev;
    logic                         rise;

    if (QUAL_CYC < 1 || QUAL_CYC >= (2 ** CW))
        $error("chan_qual: QUAL_CYC does not fit the counter");

    assign rise = ch.level & ~prev;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        unique case (state)
            relay_drive_pkg::Q_IDLE: begin
                next_cnt = '0;
                if (rise && !ch.clr) begin
                    next_state = relay_drive_pkg::Q_COUNT;
                end
            end
            relay_drive_pkg::Q_COUNT: begin
                if (ch.clr || !ch.level) begin
                    next_state = relay_drive_pkg::Q_IDLE;
                end else if (cnt == CW'(QUAL_CYC - 1)) begin
                    next_state = relay_drive_pkg::Q_QUAL;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            relay_drive_pkg::Q_QUAL: begin
                if (ch.clr) begin
                    next_state = relay_drive_pkg::Q_IDLE;
                end
            end
            default: begin
                next_state = relay_drive_pkg::Q_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= relay_drive_pkg::Q_IDLE;
            cnt   <= '0;
            prev  <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            prev  <= ch.level;
        end
    end

    assign ch.counting  = (state == relay_drive_pkg::Q_COUNT);
    assign ch.qualified = (state == relay_drive_pkg::Q_QUAL);
endmodule : chan_qual

// >>> design/relay_drive_ctrl.sv
// dual-coil latching relay drive control, top level
`timescale 1ns/1ps
`include "relay_drive_cfg.svh"

module relay_drive_ctrl #(
    parameter int                         QUAL_CYC = `RLY_QUAL_CYC,
    parameter int                         MAX_CYC  = `RLY_MAX_CYC,
    parameter relay_drive_pkg::out_mode_t OUT_MODE = relay_drive_pkg::MODE_FOLLOW
) (
    input  wire logic i_ref_clk,
    input  wire logic i_srst,
    input  wire logic i_cmd_in_a,
    input  wire logic i_cmd_in_b,
    input  wire logic i_enable,
    input  wire logic i_supply_above_on,
    input  wire logic i_supply_above_off,
    input  wire logic i_overtemp_shutdown,
    output logic      o_coil_drive_a,
    output logic      o_coil_drive_a_oe_n,
    output logic      o_coil_drive_b,
    output logic      o_coil_drive_b_oe_n,
    output logic      o_supply_low_lockout
);
    localparam int EN_CYC = (`RLY_EN_CYC < 1) ? 1 : `RLY_EN_CYC;
    localparam int QW     = $clog2(QUAL_CYC + 1);
    localparam int MW     = $clog2(MAX_CYC + 1);
    localparam int EW     = $clog2(EN_CYC + 1);

    if (QUAL_CYC < 1 || MAX_CYC < 1)
        $error("relay_drive_ctrl: QUAL_CYC and MAX_CYC must be at least one cycle");

    // coil output off unless this channel is the one being driven
    function automatic logic coil_oe_n(input relay_drive_pkg::drive_state_t st,
                                       input relay_drive_pkg::chan_sel_t    sel,
                                       input relay_drive_pkg::chan_sel_t    ch);
        coil_oe_n = !((st == relay_drive_pkg::D_DRIVE) && (sel == ch));
    endfunction : coil_oe_n

    // two-stage synchronisers for all pins
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic       cmd_a;
    logic       cmd_b;
    logic       en_raw;
    logic       above_on;
    logic       above_off;
    logic       overtemp;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            pin_meta <= `RLY_SYNC_RST;
            pin_sync <= `RLY_SYNC_RST;
        end else begin
            pin_meta <= {i_cmd_in_a, i_cmd_in_b, i_enable,
                         i_supply_above_on, i_supply_above_off, i_overtemp_shutdown};
            pin_sync <= pin_meta;
        end
    end

    assign {cmd_a, cmd_b, en_raw, above_on, above_off, overtemp} = pin_sync;

    // supply hysteresis and enable filter
    logic          supply_ok;
    logic          next_supply_ok;
    logic          en_filt;
    logic          next_en_filt;
    logic [EW-1:0] en_cnt;
    logic [EW-1:0] next_en_cnt;

    always_comb begin
        next_supply_ok = supply_ok;
        if (!supply_ok && above_on) begin
            next_supply_ok = 1'b1;
        end else if (supply_ok && !above_off) begin
            next_supply_ok = 1'b0;
        end
        next_en_filt = en_filt;
        next_en_cnt  = '0;
        if (en_raw != en_filt) begin
            if (en_cnt == EW'(EN_CYC - 1)) begin
                next_en_filt = en_raw;
            end else begin
                next_en_cnt = en_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            supply_ok <= 1'b0;
            en_filt   <= 1'b0;
            en_cnt    <= '0;
        end else begin
            supply_ok <= next_supply_ok;
            en_filt   <= next_en_filt;
            en_cnt    <= next_en_cnt;
        end
    end

    // operation allowed only with supply good, no overtemperature, enable high
    // next supply state, so lockout flag and drive change on one edge
    logic oper;
    assign oper = next_supply_ok && !overtemp && en_filt;

    // channel qualifiers
    chan_if ch_a ();
    chan_if ch_b ();

    chan_qual #(.QUAL_CYC(QUAL_CYC), .CW(QW)) u_qual_a (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .ch        (ch_a)
    );

    chan_qual #(.QUAL_CYC(QUAL_CYC), .CW(QW)) u_qual_b (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .ch        (ch_b)
    );

    // drive sequencer
    relay_drive_pkg::drive_state_t state;
    relay_drive_pkg::drive_state_t next_state;
    relay_drive_pkg::chan_sel_t    sel;
    relay_drive_pkg::chan_sel_t    next_sel;
    logic [MW-1:0]                 pcnt;
    logic [MW-1:0]                 next_pcnt;
    logic                          both_qual;
    logic                          commit_a;
    logic                          commit_b;
    logic                          sel_level;
    logic                          pulse_end;
    logic                          clr_all;
    logic                          next_oe_a_n;
    logic                          next_oe_b_n;
    logic                          next_lockout;

    assign both_qual = ch_a.qualified && ch_b.qualified;
    assign commit_a  = ch_a.qualified && !ch_b.qualified && !ch_b.counting;
    assign commit_b  = ch_b.qualified && !ch_a.qualified && !ch_a.counting;
    assign sel_level = (sel == relay_drive_pkg::CH_A) ? cmd_a : cmd_b;
    assign pulse_end = (pcnt == MW'(MAX_CYC - 1))
                    || ((OUT_MODE == relay_drive_pkg::MODE_FOLLOW) && !sel_level);

    // qualifiers held idle while not operating, while driving, and after a decision
    assign clr_all = !oper || (state == relay_drive_pkg::D_DRIVE)
                  || both_qual || commit_a || commit_b;

    assign ch_a.level = cmd_a;
    assign ch_b.level = cmd_b;
    assign ch_a.clr   = clr_all;
    assign ch_b.clr   = clr_all;

    // pin controls; coil b also held off whenever coil a is on
    assign next_oe_a_n  = coil_oe_n(next_state, next_sel, relay_drive_pkg::CH_A);
    assign next_oe_b_n  = coil_oe_n(next_state, next_sel, relay_drive_pkg::CH_B) || !next_oe_a_n;
    assign next_lockout = !next_supply_ok;

    always_comb begin
        next_state = state;
        next_sel   = sel;
        next_pcnt  = '0;
        unique case (state)
            relay_drive_pkg::D_IDLE: begin
                if (oper && commit_a) begin
                    next_state = relay_drive_pkg::D_DRIVE;
                    next_sel   = relay_drive_pkg::CH_A;
                end else if (oper && commit_b) begin
                    next_state = relay_drive_pkg::D_DRIVE;
                    next_sel   = relay_drive_pkg::CH_B;
                end
            end
            relay_drive_pkg::D_DRIVE: begin
                if (!oper || pulse_end) begin
                    next_state = relay_drive_pkg::D_IDLE;
                end else begin
                    next_pcnt = pcnt + 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state               <= relay_drive_pkg::D_IDLE;
            sel                 <= relay_drive_pkg::CH_A;
            pcnt                <= '0;
            o_coil_drive_a      <= `RLY_PIN_IDLE;
            o_coil_drive_b      <= `RLY_PIN_IDLE;
            o_coil_drive_a_oe_n <= `RLY_OE_N_OFF;
            o_coil_drive_b_oe_n <= `RLY_OE_N_OFF;
            o_supply_low_lockout <= 1'b1;
        end else begin
            state               <= next_state;
            sel                 <= next_sel;
            pcnt                <= next_pcnt;
            o_coil_drive_a      <= `RLY_PIN_IDLE;
            o_coil_drive_b      <= `RLY_PIN_IDLE;
            o_coil_drive_a_oe_n <= next_oe_a_n;
            o_coil_drive_b_oe_n <= next_oe_b_n;
            o_supply_low_lockout <= next_lockout;
        end
    end
endmodule : relay_drive_ctrl

// >>> tb/relay_drive_ctrl_assertions.sv
// port assertions for the relay drive control
`timescale 1ns/1ps
module relay_drive_ctrl_assertions #(
    parameter int QUAL_CYC = 20,
    parameter int MAX_CYC  = 100
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_cmd_in_a,
    input wire logic i_enable,
    input wire logic i_supply_above_on,
    input wire logic i_supply_above_off,
    input wire logic i_overtemp_shutdown,
    input wire logic o_coil_drive_a_oe_n,
    input wire logic o_coil_drive_b_oe_n,
    input wire logic o_supply_low_lockout
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    int   en_low = 0;
    int   on_a   = 0;
    int   on_b   = 0;
    logic off;
    assign off = o_coil_drive_a_oe_n && o_coil_drive_b_oe_n;
    always @(posedge i_ref_clk) begin
        en_low <= i_enable ? 0 : (en_low < 60 ? en_low + 1 : 60);
        on_a   <= o_coil_drive_a_oe_n ? 0 : on_a + 1;
        on_b   <= o_coil_drive_b_oe_n ? 0 : on_b + 1;
    end
    sequence s_end_a;
        $rose(o_coil_drive_a_oe_n) && i_cmd_in_a;
    endsequence
    property p_excl; !(!o_coil_drive_a_oe_n && !o_coil_drive_b_oe_n); endproperty
    a_excl: assert property (p_excl) else $error("both coils driven");
    property p_lock; o_supply_low_lockout |=> off; endproperty
    a_lock: assert property (p_lock) else $error("drive in lockout");
    property p_rst; $fell(i_srst) |-> off && o_supply_low_lockout; endproperty
    a_rst: assert property (p_rst) else $error("drive at reset release");
    property p_fall; (!i_supply_above_off) [*4] |=> o_supply_low_lockout; endproperty
    a_fall: assert property (p_fall) else $error("lockout not entered");
    property p_rise; (i_supply_above_on && i_supply_above_off) [*6] |=> !o_supply_low_lockout; endproperty
    a_rise: assert property (p_rise) else $error("lockout not left");
    property p_hot; i_overtemp_shutdown [*4] |-> off; endproperty
    a_hot: assert property (p_hot) else $error("drive while hot");
    property p_en; en_low >= 56 |-> off; endproperty
    a_en: assert property (p_en) else $error("drive while disabled");
    property p_qual; $fell(o_coil_drive_a_oe_n) |-> $past(i_cmd_in_a, QUAL_CYC); endproperty
    a_qual: assert property (p_qual) else $error("pulse without qualified input");
    property p_max; on_a <= MAX_CYC && on_b <= MAX_CYC; endproperty
    a_max: assert property (p_max) else $error("pulse too long");
    property p_stuck; s_end_a |=> (o_coil_drive_a_oe_n || !i_cmd_in_a) [*8]; endproperty
    a_stuck: assert property (p_stuck) else $error("pulse from held input");
endmodule : relay_drive_ctrl_assertions

// >>> tb/relay_cmd_src.sv
// command source model driving the two command pins
`timescale 1ns/1ps
module relay_cmd_src (
    input  wire logic        i_ref_clk,
    input  wire logic        i_go_a,
    input  wire logic        i_go_b,
    input  wire logic [15:0] i_len_a,
    input  wire logic [15:0] i_len_b,
    output logic             o_cmd_a,
    output logic             o_cmd_b
);
    logic [15:0] left_a = 16'h0000;
    logic [15:0] left_b = 16'h0000;
    always @(posedge i_ref_clk) begin
        left_a <= i_go_a ? i_len_a : left_a - 16'(left_a != 16'h0000);
        left_b <= i_go_b ? i_len_b : left_b - 16'(left_b != 16'h0000);
    end
    assign o_cmd_a = left_a != 16'h0000;
    assign o_cmd_b = left_b != 16'h0000;
endmodule : relay_cmd_src

// >>> tb/test_relay_drive_ctrl.sv
// testbench for the relay drive control
`timescale 1ns/1ps
module test_relay_drive_ctrl;
    localparam int Q = 20;
    localparam int M = 100;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        en = 1'b0;
    logic        sup_on = 1'b0;
    logic        sup_off = 1'b0;
    logic        hot = 1'b0;
    logic        go_a = 1'b0;
    logic        go_b = 1'b0;
    logic [15:0] len_a = 16'h0000;
    logic [15:0] len_b = 16'h0000;
    logic        cmd_a, cmd_b, oe_a_n, oe_b_n, lockout;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          on_a;
    int          on_b;
    int          on_fa;
    int          on_fb;
    int          pin_hi;
    logic        drv_a;
    logic        drv_b;
    logic        oe_fa_n;
    logic        oe_fb_n;
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            final_report();
        end
    end
    relay_cmd_src src_u (.i_ref_clk(clk), .i_go_a(go_a), .i_go_b(go_b), .i_len_a(len_a), .i_len_b(len_b),
        .o_cmd_a(cmd_a), .o_cmd_b(cmd_b));
    relay_drive_ctrl #(.QUAL_CYC(Q), .MAX_CYC(M)) dut_u (.i_ref_clk(clk), .i_srst(srst), .i_cmd_in_a(cmd_a),
        .i_cmd_in_b(cmd_b), .i_enable(en), .i_supply_above_on(sup_on), .i_supply_above_off(sup_off),
        .i_overtemp_shutdown(hot), .o_coil_drive_a(drv_a), .o_coil_drive_a_oe_n(oe_a_n), .o_coil_drive_b(drv_b),
        .o_coil_drive_b_oe_n(oe_b_n), .o_supply_low_lockout(lockout));
    relay_drive_ctrl #(.QUAL_CYC(Q), .MAX_CYC(M), .OUT_MODE(relay_drive_pkg::MODE_FIXED)) dut_fix_u (
        .i_ref_clk(clk), .i_srst(srst), .i_cmd_in_a(cmd_a), .i_cmd_in_b(cmd_b), .i_enable(en),
        .i_supply_above_on(sup_on), .i_supply_above_off(sup_off), .i_overtemp_shutdown(hot),
        .o_coil_drive_a(), .o_coil_drive_a_oe_n(oe_fa_n), .o_coil_drive_b(), .o_coil_drive_b_oe_n(oe_fb_n),
        .o_supply_low_lockout());
    task automatic check(input string name, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask : check
    // pulse a at 0, pulse b at db, optional disable at cycle 30
    task automatic run(input int la, input int lb, input int db, input int dis);
        on_a = 0;
        on_b = 0;
        on_fa = 0;
        on_fb = 0;
        pin_hi = 0;
        for (int i = 0; i < 200; i++) begin
            @(posedge clk);
            go_a <= (i == 0);
            go_b <= (i == db);
            len_a <= la[15:0];
            len_b <= lb[15:0];
            if (i == 30 && dis == 1) en <= 1'b0;
            if (i == 30 && dis == 2) hot <= 1'b1;
            if (i == 30 && dis == 3) sup_on <= 1'b0;
            if (i == 30 && dis == 3) sup_off <= 1'b0;
            @(negedge clk);
            on_a += int'(oe_a_n === 1'b0);
            on_b += int'(oe_b_n === 1'b0);
            on_fa += int'(oe_fa_n === 1'b0);
            on_fb += int'(oe_fb_n === 1'b0);
            pin_hi += int'(drv_a !== 1'b0 || drv_b !== 1'b0);
        end
        @(posedge clk);
        en <= 1'b1;
        hot <= 1'b0;
        sup_on <= 1'b1;
        sup_off <= 1'b1;
        repeat (300) @(posedge clk);
    endtask : run
    task automatic t_short; run(Q - 5, 0, 0, 0); check("short", on_a == 0, 1'b1); endtask : t_short
    task automatic t_follow;
        run(40, 0, 0, 0);
        check("follow", on_a > 10 && on_a < 25, 1'b1);
        check("fixed", on_fa == M, 1'b1);
    endtask : t_follow
    task automatic t_cap;
        run(0, 400, 0, 0);
        check("cap", on_b >= M - 1 && on_b <= M, 1'b1);
        check("fixed cap", on_fb == M, 1'b1);
        check("pin value", pin_hi == 0, 1'b1);
    endtask : t_cap
    task automatic t_overlap; run(80, 80, 45, 0); check("overlap", on_a > 0 && on_b == 0, 1'b1); endtask : t_overlap
    task automatic t_both; run(60, 60, 0, 0); check("both", on_a + on_b == 0, 1'b1); endtask : t_both
    task automatic t_pend; run(60, 15, 10, 0); check("pending", on_a > 0 && on_b == 0, 1'b1); endtask : t_pend
    task automatic t_en; run(400, 0, 0, 1); check("enable", on_a > 45 && on_a < 70, 1'b1); endtask : t_en
    task automatic t_hot; run(400, 0, 0, 2); check("hot", on_a > 0 && on_a < 15, 1'b1); endtask : t_hot
    task automatic t_sup; run(400, 0, 0, 3); check("supply", on_a > 0 && on_a < 15, 1'b1); endtask : t_sup
    task automatic final_report;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        check("reset oe", oe_a_n & oe_b_n, 1'b1);
        check("reset lockout", lockout, 1'b1);
        @(posedge clk);
        sup_on <= 1'b1;
        sup_off <= 1'b1;
        en <= 1'b1;
        repeat (80) @(posedge clk);
        sup_on <= 1'b0;
        repeat (20) @(negedge clk);
        check("hysteresis", lockout, 1'b0);
        @(posedge clk);
        sup_on <= 1'b1;
        t_short();
        t_follow();
        t_cap();
        t_overlap();
        t_both();
        t_pend();
        t_en();
        t_hot();
        t_sup();
        final_report();
    end
endmodule : test_relay_drive_ctrl
bind relay_drive_ctrl relay_drive_ctrl_assertions #(.QUAL_CYC(QUAL_CYC), .MAX_CYC(MAX_CYC)) chk_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cmd_in_a(i_cmd_in_a), .i_enable(i_enable),
    .i_supply_above_on(i_supply_above_on), .i_supply_above_off(i_supply_above_off),
    .i_overtemp_shutdown(i_overtemp_shutdown), .o_coil_drive_a_oe_n(o_coil_drive_a_oe_n),
    .o_coil_drive_b_oe_n(o_coil_drive_b_oe_n), .o_supply_low_lockout(o_supply_low_lockout));
